//--- rtl/holdover_defs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef HOLDOVER_DEFS_SVH
`define HOLDOVER_DEFS_SVH

`define ADDR_CTRL 32'h0000_0000
`define ADDR_CAP_LIMITS 32'h0000_0004
`define ADDR_ERR_LIMIT 32'h0000_0008
`define ADDR_STATUS 32'h0000_000C
`define ADDR_TUNE_CODE 32'h0000_0010
`define ADDR_XTAL_PERIOD 32'h0000_0014

`define CTRL_TRACK_BIT 0
`define STAT_FLAG_BIT 0
`define STAT_RANGE_BIT 1
`define STAT_STATE_LSB 2
`define STAT_RATIO_LSB 4
`define STAT_SOURCE_BIT 6
`define STAT_LOOP_BIT 7

`define CTRL_TRACK_RST 1'b1
`define CAP_MIN_RST 8'h00
`define CAP_MAX_RST 8'h30
`define CAP_MID_RST 8'h18
`define ERR_LIMIT_RST 8'h02
`define PIN_SYNC_RST 7'h18

`define PCLK_NS 20
`define GUARD_NS 25
`define FAIL_PERIODS 2
`define RESTORE_PERIODS 12
`define WINDOW_REFS 6
`define RESTORE_GUARD_CYC ((`GUARD_NS + `PCLK_NS - 1) / `PCLK_NS)

`endif

//--- rtl/holdover_pkg.sv
// Types shared by the holdover clock buffer control logic
package holdover_pkg;

  typedef enum logic [1:0] {
    ST_HOLDOVER = 2'b00,
    ST_ACQUIRE = 2'b01,
    ST_TRACK = 2'b10
  } lock_state_t;

  typedef enum logic [1:0] {
    RATIO_BYPASS = 2'b00,
    RATIO_HALF = 2'b01,
    RATIO_TWO = 2'b10,
    RATIO_SIX = 2'b11
  } ratio_t;

endpackage : holdover_pkg

//--- rtl/ctrl_bus_if.sv
// Configuration and status carried between register file and control core
`timescale 1ns/1ps
interface ctrl_bus_if;
  logic track_en;
  logic [7:0] cap_min;
  logic [7:0] cap_max;
  logic [7:0] err_limit;
  logic flag;
  logic out_range;
  logic loop_active;
  logic source;
  logic [1:0] state;
  logic [1:0] ratio;
  logic [7:0] cap_code;
  logic [15:0] xtal_period;

  modport regs (
    output track_en, cap_min, cap_max, err_limit,
    input flag, out_range, loop_active, source, state, ratio, cap_code, xtal_period
  );

  modport core (
    input track_en, cap_min, cap_max, err_limit,
    output flag, out_range, loop_active, source, state, ratio, cap_code, xtal_period
  );
endinterface : ctrl_bus_if

//--- rtl/pin_sync.sv
// Two-stage pin synchroniser with a third stage for rising-edge detection
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pin_raw,
  output logic [W-1:0] pin_s,
  output logic [W-1:0] pin_rise
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] last_reg;

  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          meta_reg[i] <= RST[i];
          sync_reg[i] <= RST[i];
          last_reg[i] <= RST[i];
        end
        else
        begin
          meta_reg[i] <= pin_raw[i];
          sync_reg[i] <= meta_reg[i];
          last_reg[i] <= sync_reg[i];
        end
      end
      assign pin_rise[i] = sync_reg[i] & ~last_reg[i];
    end
  endgenerate

  assign pin_s = sync_reg;
endmodule : pin_sync

//--- rtl/apb_regs.sv
// APB slave holding configuration and exposing status of the control core
`timescale 1ns/1ps
`include "holdover_defs.svh"
module apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ctrl_bus_if.regs cb
);
  wire setup = psel & ~penable;
  wire wr_fire = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == `ADDR_CTRL;
  wire hit_lim = paddr == `ADDR_CAP_LIMITS;
  wire hit_err = paddr == `ADDR_ERR_LIMIT;
  wire hit_stat = paddr == `ADDR_STATUS;
  wire hit_tune = paddr == `ADDR_TUNE_CODE;
  wire hit_xper = paddr == `ADDR_XTAL_PERIOD;
  wire mapped = hit_ctrl | hit_lim | hit_err | hit_stat | hit_tune | hit_xper;
  wire [7:0] status = {cb.loop_active, cb.source, cb.ratio, cb.state, cb.out_range, cb.flag};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, cb.track_en} :
                       hit_lim ? {16'h0000, cb.cap_max, cb.cap_min} :
                       hit_err ? {24'h00_0000, cb.err_limit} :
                       hit_stat ? {24'h00_0000, status} :
                       hit_tune ? {24'h00_0000, cb.cap_code} :
                       hit_xper ? {16'h0000, cb.xtal_period} : 32'h0000_0000;

  // Zero wait states: answer is ready in the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup)
        prdata <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  // Status registers ignore writes without an error
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cb.track_en <= `CTRL_TRACK_RST;
      cb.cap_min <= `CAP_MIN_RST;
      cb.cap_max <= `CAP_MAX_RST;
      cb.err_limit <= `ERR_LIMIT_RST;
    end
    else if (wr_fire)
    begin
      if (hit_ctrl)
        cb.track_en <= pwdata[`CTRL_TRACK_BIT];
      if (hit_lim)
      begin
        cb.cap_min <= pwdata[7:0];
        cb.cap_max <= pwdata[15:8];
      end
      if (hit_err)
        cb.err_limit <= pwdata[7:0];
    end
  end
endmodule : apb_regs

//--- rtl/holdover_clock_buffer_ctrl.sv
// Control core of a holdover zero-delay clock buffer with APB registers
//
// Contract
// - source_choice high selects reference A, low selects reference B.
// - Ratio code 00 bypasses loop and crystal; reference goes straight out.
// - Ratio code 01 is 1/2, 10 is 2, 11 is 6, reference to crystal.
// - Four outputs in two banks, all at reference frequency, phase aligned.
// - Valid flag high while selected reference valid, low while invalid.
// - On reference loss freeze crystal tuning; outputs continue glitch free.
// - Flag falls within two crystal periods plus 25 ns after failure.
// - Flag rises no earlier than twelve crystal periods plus 25 ns.
// - Track only while reference over ratio is in capture range.
// - Tuning resumes automatically when a valid reference returns.
// - Loop is always clocked from the crystal, never from a reference.
// - Crystal tuned by a digital capacitor code, about 300 ppm range.
// - Ratio selects default high; references, loop return and outputs low.
`timescale 1ns/1ps
`include "holdover_defs.svh"
module holdover_clock_buffer_ctrl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_a_in,
  input wire logic ref_b_in,
  input wire logic source_choice,
  input wire logic [1:0] ratio_sel,
  input wire logic loop_return_in,
  input wire logic crystal_in,
  output logic crystal_out,
  output logic [1:0] bank_a_out,
  output logic [1:0] bank_b_out,
  output logic valid_flag,
  output logic [7:0] tuning_code
);
  localparam int PINS = 7;
  localparam logic [7:0] FAIL_EXTRA = 8'(`FAIL_PERIODS);
  // One extra edge: the first counted edge only opens the first full period
  localparam logic [7:0] RESTORE_CNT = 8'(`RESTORE_PERIODS + 1);
  localparam logic [2:0] GUARD_CNT = 3'(`RESTORE_GUARD_CYC);
  localparam logic [3:0] WIN_LAST = 4'(`WINDOW_REFS - 1);

  ctrl_bus_if cb ();

  apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cb(cb.regs)
  );

  logic [PINS-1:0] pin_s;
  logic [PINS-1:0] pin_rise;
  wire [PINS-1:0] pin_raw = {crystal_in, loop_return_in, ratio_sel, source_choice,
                             ref_b_in, ref_a_in};

  // undriven default
  // Synchroniser resets mirror the pin pulls: ratio selects high, source select and clocks low
  pin_sync #(
    .W(PINS),
    .RST(`PIN_SYNC_RST)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_raw(pin_raw),
    .pin_s(pin_s),
    .pin_rise(pin_rise)
  );

  wire sel_ref = pin_s[2] ? pin_s[0] : pin_s[1];
  wire ref_edge = pin_s[2] ? pin_rise[0] : pin_rise[1];
  wire xtal_edge = pin_rise[6];
  wire loop_edge = pin_rise[5];
  wire holdover_pkg::ratio_t ratio = holdover_pkg::ratio_t'(pin_s[4:3]);
  wire bypass = ratio == holdover_pkg::RATIO_BYPASS;

  // crystal edges per reference period and per window
  function automatic logic [7:0] gap_per_ref(input holdover_pkg::ratio_t r);
    // Faster references leave no whole crystal edge per gap, so the limit stays tight
    gap_per_ref = (r == holdover_pkg::RATIO_HALF) ? 8'h02 : 8'h00;
  endfunction : gap_per_ref

  function automatic logic [7:0] win_expect(input holdover_pkg::ratio_t r);
    unique case (r)
      holdover_pkg::RATIO_HALF: win_expect = 8'(`WINDOW_REFS * 2);
      holdover_pkg::RATIO_TWO: win_expect = 8'(`WINDOW_REFS / 2);
      holdover_pkg::RATIO_SIX: win_expect = 8'(`WINDOW_REFS / 6);
      holdover_pkg::RATIO_BYPASS: win_expect = 8'h00;
    endcase
  endfunction : win_expect

  holdover_pkg::lock_state_t state_reg;
  holdover_pkg::lock_state_t state_next;
  logic [7:0] gap_cnt_reg;
  logic [3:0] win_ref_reg;
  logic [7:0] win_xtal_reg;
  logic win_done_reg;
  logic win_bad_reg;
  logic out_range_reg;
  logic [7:0] cap_code_reg;
  logic [7:0] acq_cnt_reg;
  logic [2:0] guard_cnt_reg;
  logic [15:0] xper_cnt_reg;
  logic [15:0] xtal_period_reg;
  logic [15:0] nco_cnt_reg;
  logic nco_clk_reg;
  logic loop_seen_reg;
  logic loop_active_reg;
  logic flag_reg;
  logic crystal_out_reg;
  logic [1:0] bank_a_reg;
  logic [1:0] bank_b_reg;

  // limit is one expected gap plus two crystal periods
  wire [7:0] gap_limit = gap_per_ref(ratio) + FAIL_EXTRA;
  wire ref_lost = gap_cnt_reg >= gap_limit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      gap_cnt_reg <= 8'h00;
    else if (ref_edge)
      gap_cnt_reg <= 8'h00;
    else if (xtal_edge && !ref_lost)
      gap_cnt_reg <= gap_cnt_reg + 8'h01;
  end

  // frequency window over a fixed count of reference edges
  wire win_close = ref_edge && (win_ref_reg == WIN_LAST);
  wire [8:0] win_err = {1'b0, win_xtal_reg} - {1'b0, win_expect(ratio)};
  wire [8:0] win_mag = win_err[8] ? 9'(-win_err) : win_err;
  wire xtal_fast = !win_err[8] && (win_err != 9'h000);
  wire xtal_slow = win_err[8];
  wire at_max = cap_code_reg >= cb.cap_max;
  wire at_min = cap_code_reg <= cb.cap_min;
  wire rail_hit = (xtal_fast && at_max) || (xtal_slow && at_min);
  wire win_fail = !bypass && ((win_mag > {1'b0, cb.err_limit}) || rail_hit);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      win_ref_reg <= 4'h0;
      win_xtal_reg <= 8'h00;
      win_done_reg <= 1'b0;
      win_bad_reg <= 1'b0;
    end
    else
    begin
      win_done_reg <= win_close;
      if (win_close)
        win_bad_reg <= win_fail;
      if (win_close || ref_lost)
      begin
        win_ref_reg <= 4'h0;
        // An edge on the closing cycle opens the next window, so none is lost
        win_xtal_reg <= {7'h00, xtal_edge};
      end
      else
      begin
        if (ref_edge)
          win_ref_reg <= win_ref_reg + 4'h1;
        if (xtal_edge && win_xtal_reg != 8'hFF)
          win_xtal_reg <= win_xtal_reg + 8'h01;
      end
    end
  end

  // Range result stands until the next complete window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      out_range_reg <= 1'b0;
    else if (win_done_reg)
      out_range_reg <= win_bad_reg;
  end

  // capacitor code steps one unit per good window
  // no step outside acquire or track, so holdover keeps the last code
  // stepping resumes by itself once acquire is entered again
  wire tune_ok = cb.track_en && !bypass && !win_fail &&
                 (state_reg != holdover_pkg::ST_HOLDOVER);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cap_code_reg <= `CAP_MID_RST;
    else if (win_close && tune_ok)
    begin
      if (xtal_fast)
        cap_code_reg <= cap_code_reg + 8'h01;
      else if (xtal_slow)
        cap_code_reg <= cap_code_reg - 8'h01;
    end
  end

  // restore needs twelve crystal periods then the 25 ns guard
  wire restore_done = (acq_cnt_reg >= RESTORE_CNT) && (guard_cnt_reg >= GUARD_CNT);
  wire lose_lock = ref_lost || (win_done_reg && win_bad_reg);

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      holdover_pkg::ST_HOLDOVER:
        if (ref_edge)
          state_next = holdover_pkg::ST_ACQUIRE;
      holdover_pkg::ST_ACQUIRE:
        if (lose_lock)
          state_next = holdover_pkg::ST_HOLDOVER;
        else if (restore_done)
          state_next = holdover_pkg::ST_TRACK;
      holdover_pkg::ST_TRACK:
        if (lose_lock)
          state_next = holdover_pkg::ST_HOLDOVER;
      default:
        state_next = holdover_pkg::ST_HOLDOVER;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_reg <= holdover_pkg::ST_HOLDOVER;
    else
      state_reg <= state_next;
  end

  // Acquire counters restart on every entry so a flicker cannot shorten the wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acq_cnt_reg <= 8'h00;
      guard_cnt_reg <= 3'h0;
    end
    else if (state_reg != holdover_pkg::ST_ACQUIRE)
    begin
      acq_cnt_reg <= 8'h00;
      guard_cnt_reg <= 3'h0;
    end
    else if (acq_cnt_reg < RESTORE_CNT)
    begin
      if (xtal_edge)
        acq_cnt_reg <= acq_cnt_reg + 8'h01;
    end
    else if (guard_cnt_reg < GUARD_CNT)
      guard_cnt_reg <= guard_cnt_reg + 3'h1;
  end

  // flag follows the state that will hold after this edge
  // loss drops the flag on the edge that sees the count limit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_reg <= 1'b0;
    else
      flag_reg <= state_next == holdover_pkg::ST_TRACK;
  end

  // crystal period in system clocks is the only loop time base
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xper_cnt_reg <= 16'h0000;
      xtal_period_reg <= 16'h0000;
    end
    else if (xtal_edge)
    begin
      xper_cnt_reg <= 16'h0000;
      xtal_period_reg <= xper_cnt_reg + 16'h0001;
    end
    else if (xper_cnt_reg != 16'hFFFF)
      xper_cnt_reg <= xper_cnt_reg + 16'h0001;
  end

  // output period equals crystal period divided by the ratio
  // Divide by six is approximated as 43/256, good to under one percent
  wire [23:0] xp_sixth = {8'h00, xtal_period_reg} * 24'h00002B;
  wire [15:0] out_period = (ratio == holdover_pkg::RATIO_HALF) ? {xtal_period_reg[14:0], 1'b0} :
                           (ratio == holdover_pkg::RATIO_TWO) ? {1'b0, xtal_period_reg[15:1]} :
                           xp_sixth[23:8];
  wire [15:0] half_raw = {1'b0, out_period[15:1]};
  wire [15:0] half_period = (half_raw == 16'h0000) ? 16'h0001 : half_raw;

  // phase aligned to the reference edge, only while tracking
  // no realignment in holdover so the held clock never glitches
  wire align = ref_edge && (state_reg == holdover_pkg::ST_TRACK) && !bypass;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nco_cnt_reg <= 16'h0000;
      nco_clk_reg <= 1'b0;
    end
    else if (align)
    begin
      nco_cnt_reg <= 16'h0000;
      nco_clk_reg <= 1'b1;
    end
    else if (nco_cnt_reg >= half_period - 16'h0001)
    begin
      nco_cnt_reg <= 16'h0000;
      nco_clk_reg <= ~nco_clk_reg;
    end
    else
      nco_cnt_reg <= nco_cnt_reg + 16'h0001;
  end

  // loop return activity is reported once per window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      loop_seen_reg <= 1'b0;
      loop_active_reg <= 1'b0;
    end
    else if (win_done_reg)
    begin
      loop_active_reg <= loop_seen_reg || loop_edge;
      loop_seen_reg <= 1'b0;
    end
    else if (loop_edge)
      loop_seen_reg <= 1'b1;
  end

  // two banks of two, each from its own flop to keep skew equal
  // bypass feeds the synchronised reference straight to the banks
  genvar i;
  generate
    for (i = 0; i < 2; i++)
    begin : g_bank
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          bank_a_reg[i] <= 1'b0;
          bank_b_reg[i] <= 1'b0;
        end
        else
        begin
          bank_a_reg[i] <= bypass ? sel_ref : nco_clk_reg;
          bank_b_reg[i] <= bypass ? sel_ref : nco_clk_reg;
        end
      end
    end
  endgenerate

  // Crystal drive is the inverted sampled input, held low in bypass
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      crystal_out_reg <= 1'b0;
    else
      crystal_out_reg <= !bypass && !pin_s[6];
  end

  assign cb.flag = flag_reg;
  assign cb.out_range = out_range_reg;
  assign cb.loop_active = loop_active_reg;
  assign cb.source = pin_s[2];
  assign cb.state = state_reg;
  assign cb.ratio = pin_s[4:3];
  assign cb.cap_code = cap_code_reg;
  assign cb.xtal_period = xtal_period_reg;

  assign valid_flag = flag_reg;
  assign tuning_code = cap_code_reg;
  assign crystal_out = crystal_out_reg;
  assign bank_a_out = bank_a_reg;
  assign bank_b_out = bank_b_reg;
endmodule : holdover_clock_buffer_ctrl

//--- tb/holdover_clock_buffer_ctrl_monitor.sv
// Port-level assertion checker for the holdover clock buffer control block
`timescale 1ns/1ps
module holdover_clock_buffer_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ref_a_in,
  input wire logic ref_b_in,
  input wire logic source_choice,
  input wire logic [1:0] ratio_sel,
  input wire logic crystal_in,
  input wire logic crystal_out,
  input wire logic [1:0] bank_a_out,
  input wire logic [1:0] bank_b_out,
  input wire logic valid_flag,
  input wire logic [7:0] tuning_code
);
  logic xd_reg, rd_reg, sc_reg;
  logic [7:0] gap_reg, xlow_reg;
  wire logic sel_ref = source_choice ? ref_a_in : ref_b_in;
  wire logic x_rise = crystal_in && !xd_reg;
  wire logic r_rise = sel_ref && !rd_reg;

  // Sampled without the design's sync stages, so these counts lead the design's own
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      xd_reg <= 1'b0;
      rd_reg <= 1'b0;
      sc_reg <= 1'b0;
      gap_reg <= 8'h00;
      xlow_reg <= 8'h00;
    end
    else
    begin
      xd_reg <= crystal_in;
      rd_reg <= sel_ref;
      sc_reg <= source_choice;
      if (r_rise || source_choice != sc_reg)
        gap_reg <= 8'h00;
      else if (x_rise && gap_reg != 8'hFF)
        gap_reg <= gap_reg + 8'h01;
      if (valid_flag)
        xlow_reg <= 8'h00;
      else if (x_rise && xlow_reg != 8'hFF)
        xlow_reg <= xlow_reg + 8'h01;
    end
  end

  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_READY_AFTER_SETUP:
    assert property (psel && !penable |=> pready) else $error("pready missing after setup");
  AST_READY_IN_ACCESS:
    assert property (pready |-> psel && penable) else $error("pready outside access");
  AST_ERR_WITH_READY:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  AST_BANKS_ALIGNED:
    assert property (bank_b_out == bank_a_out && bank_a_out[0] == bank_a_out[1])
      else $error("output banks differ");
  AST_BYPASS_XTAL_OFF:
    assert property ((ratio_sel == 2'b00) [*5] |=> crystal_out == 1'b0)
      else $error("crystal driven in bypass");
  AST_FLAG_ON_LOSS:
    assert property (gap_reg >= 8'd6 |-> !valid_flag) else $error("flag high after loss");
  AST_FLAG_RISE_LATE:
    assert property ($rose(valid_flag) |-> xlow_reg >= 8'd12) else $error("flag rose early");
  AST_HOLD_FROZEN:
    assert property (gap_reg >= 8'd6 |=> $stable(tuning_code)) else $error("tuning moved");
  AST_TUNE_STEP:
    assert property ($changed(tuning_code) |-> tuning_code == $past(tuning_code) + 8'h01
      || tuning_code == $past(tuning_code) - 8'h01) else $error("tuning step not one");
endmodule : holdover_clock_buffer_ctrl_monitor

//--- tb/clock_source_model.sv
// Reference pair and crystal sources driven into the control block
`timescale 1ns/1ps
module clock_source_model (
  input wire logic pclk,
  input wire logic a_on,
  input wire logic b_on,
  input wire logic [7:0] ref_half,
  input wire logic [7:0] xtal_half,
  output logic ref_a,
  output logic ref_b,
  output logic xtal
);
  logic [7:0] rc, xc;
  logic ph;
  initial
  begin
    rc = 8'h00;
    xc = 8'h00;
    ph = 1'b0;
    xtal = 1'b0;
    ref_a = 1'b0;
    ref_b = 1'b0;
  end
  // Crystal keeps running in holdover; only references are stopped
  always @(posedge pclk)
  begin
    rc <= rc + 8'h01;
    xc <= xc + 8'h01;
    if (rc + 8'h01 >= ref_half)
    begin
      rc <= 8'h00;
      ph <= !ph;
    end
    if (xc + 8'h01 >= xtal_half)
    begin
      xc <= 8'h00;
      xtal <= !xtal;
    end
    ref_a <= a_on && ph;
    ref_b <= b_on && !ph;
  end
endmodule : clock_source_model

//--- tb/tb_holdover_clock_buffer_ctrl.sv
// Self-checking bench for the holdover clock buffer control block
`timescale 1ns/1ps
`include "holdover_defs.svh"
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) \
    begin \
      error_cnt++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
    end \
  end
module tb_holdover_clock_buffer_ctrl;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  logic ref_a_in, ref_b_in, source_choice, crystal_in, crystal_out, valid_flag;
  logic [1:0] ratio_sel, bank_a_out, bank_b_out;
  logic [7:0] tuning_code, ref_half, xtal_half;
  logic a_on, b_on;
  wire logic loop_return_in;
  int error_cnt, samples_checked;

  assign loop_return_in = bank_a_out[0];

  always #10 pclk = ~pclk;

  holdover_clock_buffer_ctrl DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ref_a_in(ref_a_in), .ref_b_in(ref_b_in),
    .source_choice(source_choice), .ratio_sel(ratio_sel), .loop_return_in(loop_return_in),
    .crystal_in(crystal_in), .crystal_out(crystal_out), .bank_a_out(bank_a_out),
    .bank_b_out(bank_b_out), .valid_flag(valid_flag), .tuning_code(tuning_code));

  clock_source_model src (.pclk(pclk), .a_on(a_on), .b_on(b_on), .ref_half(ref_half),
    .xtal_half(xtal_half), .ref_a(ref_a_in), .ref_b(ref_b_in), .xtal(crystal_in));

  task automatic results();
    $display("Checks %0d, errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results

  task automatic tmo();
    error_cnt++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    results();
  endtask : tmo

  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 16) tmo();
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_flag(input logic v, output int n);
    n = 0;
    while (valid_flag !== v)
    begin
      @(posedge pclk);
      n++;
      if (n > 5000) tmo();
    end
  endtask : wait_flag

  task automatic restart(input logic [1:0] r, input logic [7:0] rh, input logic [7:0] xh);
    @(posedge pclk);
    presetn <= 1'b0;
    ratio_sel <= r;
    ref_half <= rh;
    xtal_half <= xh;
    a_on <= 1'b1;
    b_on <= 1'b1;
    source_choice <= 1'b1;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask : restart

  task automatic t_regs();
    logic [31:0] rd;
    logic er;
    `CHK(tuning_code, 8'h18)
    apb(1'b0, `ADDR_CTRL, 32'h0, rd, er);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, `ADDR_CAP_LIMITS, 32'h0, rd, er);
    `CHK(rd, 32'h0000_3000)
    apb(1'b1, `ADDR_ERR_LIMIT, 32'h0000_0005, rd, er);
    apb(1'b0, `ADDR_ERR_LIMIT, 32'h0, rd, er);
    `CHK({er, rd}, {1'b0, 32'h0000_0005})
    apb(1'b1, `ADDR_STATUS, 32'hFFFF_FFFF, rd, er);
    `CHK(er, 1'b0)
    apb(1'b1, 32'h0000_0018, 32'hFFFF_FFFF, rd, er);
    `CHK(er, 1'b1)
    apb(1'b0, 32'h0000_0018, 32'h0, rd, er);
    `CHK({er, rd}, {1'b1, 32'h0})
    apb(1'b1, `ADDR_ERR_LIMIT, 32'h0000_0002, rd, er);
  endtask : t_regs

  // Lock, lose the chosen source, switch sources, then restore
  task automatic t_lock(input logic [1:0] r, input logic [7:0] rh, input logic [7:0] xh);
    logic [31:0] rd;
    logic er;
    logic [7:0] held;
    int n;
    restart(r, rh, xh);
    // Rise: twelve crystal periods plus the 25 ns guard at the least
    wait_flag(1'b1, n);
    `CHK(n >= 24 * xh + 2, 1'b1)
    apb(1'b0, `ADDR_STATUS, 32'h0, rd, er);
    `CHK(rd[7:0], {2'b11, r, 2'b10, 2'b01})
    a_on <= 1'b0;
    // Fall: missing edge, two crystal periods, guard and sync latency at most
    wait_flag(1'b0, n);
    `CHK(n <= 2 * rh + 4 * xh + 6, 1'b1)
    held = tuning_code;
    repeat (100) @(posedge pclk);
    `CHK(tuning_code, held)
    source_choice <= 1'b0;
    wait_flag(1'b1, n);
    `CHK(n >= 24 * xh + 2, 1'b1)
    source_choice <= 1'b1;
    wait_flag(1'b0, n);
    `CHK(n <= 2 * rh + 4 * xh + 6, 1'b1)
    a_on <= 1'b1;
    wait_flag(1'b1, n);
    `CHK(n >= 24 * xh + 2, 1'b1)
  endtask : t_lock

  task automatic t_bypass();
    int hi, xo;
    restart(2'b00, 8'h03, 8'h04);
    repeat (12) @(posedge pclk);
    hi = 0;
    xo = 0;
    repeat (60)
    begin
      @(posedge pclk);
      hi += bank_a_out[0] ? 1 : 0;
      xo += (crystal_out !== 1'b0) ? 1 : 0;
    end
    `CHK(hi, 30)
    `CHK(xo, 0)
  endtask : t_bypass

  // A slightly fast crystal steps the code; a far-off one is refused as out of range
  task automatic t_range();
    logic [31:0] rd;
    logic er;
    int hi;
    restart(2'b11, 8'h02, 8'h08);
    repeat (400) @(posedge pclk);
    `CHK(tuning_code > 8'h18, 1'b1)
    restart(2'b11, 8'h02, 8'h02);
    hi = 0;
    repeat (300)
    begin
      @(posedge pclk);
      hi += (valid_flag === 1'b1) ? 1 : 0;
    end
    apb(1'b0, `ADDR_STATUS, 32'h0, rd, er);
    `CHK({hi, rd[1:0]}, {32'h0000_0000, 2'b10})
  endtask : t_range

  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    source_choice = 1'b1;
    ratio_sel = 2'b10;
    a_on = 1'b1;
    b_on = 1'b1;
    ref_half = 8'h02;
    xtal_half = 8'h04;
    error_cnt = 0;
    samples_checked = 0;
    restart(2'b10, 8'h02, 8'h04);
    t_regs();
    t_lock(2'b01, 8'h08, 8'h04);
    t_lock(2'b10, 8'h02, 8'h04);
    t_lock(2'b11, 8'h02, 8'h0C);
    t_range();
    t_bypass();
    results();
  end
endmodule : tb_holdover_clock_buffer_ctrl

bind holdover_clock_buffer_ctrl holdover_clock_buffer_ctrl_monitor mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .ref_a_in(ref_a_in), .ref_b_in(ref_b_in), .source_choice(source_choice),
  .ratio_sel(ratio_sel), .crystal_in(crystal_in), .crystal_out(crystal_out),
  .bank_a_out(bank_a_out), .bank_b_out(bank_b_out), .valid_flag(valid_flag),
  .tuning_code(tuning_code));
